// *** carrier_gen.sv ***
// Fixed 50 percent square wave at the carrier rate
`timescale 1ns/1ps
`include "gpio_defs.svh"
module carrier_gen #(
    parameter int HALF_CYCLES = `CARRIER_HALF_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    output logic      carrier_wave
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic        wave;
    } carrier_s;

    carrier_s state_reg;
    carrier_s state_next;

    always_comb
    begin
        state_next = state_reg;
        if (state_reg.count == 16'(HALF_CYCLES - 1))
        begin
            state_next.count = 16'h0000;
            state_next.wave  = ~state_reg.wave;
        end
        else
        begin
            state_next.count = state_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign carrier_wave = state_reg.wave;
endmodule // carrier_gen

// *** ext_pins.sv ***
// Resolved pin levels with attached external devices
`timescale 1ns/1ps
module ext_pins (
    input  wire logic        sys_clk,
    input  wire logic [23:0] drv_en,
    input  wire logic [23:0] drv_val,
    input  wire logic [23:0] pullup_on,
    input  wire logic [23:0] ext_en,
    input  wire logic [23:0] ext_val,
    output logic      [23:0] level
);
    logic [23:0] float_pat = 24'h5a5a5a;
    // Undriven open pins wander each cycle
    always @(posedge sys_clk) float_pat <= ~float_pat;
    // chip driver, then device, pull-up, float
    assign level = (drv_en & drv_val) | (~drv_en & ((ext_en & ext_val)
        | (~ext_en & pullup_on) | (~ext_en & ~pullup_on & float_pat)));
endmodule // ext_pins

// *** gpio_defs.svh ***
// Offsets, field positions, reset values and timing counts of the port block
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define ADDR_PORT0_LATCH          8'h80
`define ADDR_PORT1_LATCH          8'h90
`define ADDR_PIN_MOD_SELECT       8'h9f
`define ADDR_PORT2_LATCH          8'ha0
`define ADDR_GEN_CONFIG           8'haf
`define ADDR_PORT0_PULLUP_DISABLE 8'hb2
`define ADDR_PORT1_PULLUP_DISABLE 8'hb3
`define ADDR_PORT2_PULLUP_DISABLE 8'hb4

`define CARRIER_ENABLE_BIT        4
`define PORT_LATCH_RESET          8'hff
`define PULLUP_DISABLE_RESET      8'h00
`define PIN_MOD_SELECT_RESET      8'h00
`define GEN_CONFIG_RESET          8'h00
`define PORT2_PULLUP_DISABLE_MASK 8'h27
`define RESET_PIN_PULLUP_BIT      5

`define SYS_CLK_HZ                40000000
`define CARRIER_HZ                38000
`define CARRIER_HALF_CYCLES       (`SYS_CLK_HZ / (2 * `CARRIER_HZ))

`endif

// *** gpio_pkg.sv ***
// Types shared by the port block
package gpio_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        READ_NONE,
        READ_LATCH,
        READ_PIN
    } read_kind_e;
endpackage

// *** gpio_ports.sv ***
// Three quasi-bidirectional ports with pull-up control and carrier modulation
`timescale 1ns/1ps
`include "gpio_defs.svh"
module gpio_ports #(
    parameter int CARRIER_HALF = `CARRIER_HALF_CYCLES
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic [7:0]         sfr_addr,
    input  wire logic               sfr_wr,
    input  wire logic [7:0]         sfr_wdata,
    input  wire gpio_pkg::read_kind_e sfr_rd_kind,
    output logic      [7:0]         sfr_rdata,
    input  wire logic [7:0]         periph_own0,
    input  wire logic [7:0]         periph_own1,
    input  wire logic [7:0]         periph_own2,
    input  wire logic [7:0]         periph_out0,
    input  wire logic [7:0]         periph_out1,
    input  wire logic [7:0]         periph_out2,
    input  wire logic [7:0]         port0_in,
    input  wire logic [7:0]         port1_in,
    input  wire logic [7:0]         port2_in,
    output logic      [7:0]         port0_out,
    output logic      [7:0]         port0_oe,
    output logic      [7:0]         port0_pullup_en,
    output logic      [7:0]         port1_out,
    output logic      [7:0]         port1_oe,
    output logic      [7:0]         port1_pullup_en,
    output logic      [7:0]         port2_out,
    output logic      [7:0]         port2_oe,
    output logic      [7:0]         port2_pullup_en,
    output logic                    reset_pin_pullup_en
);
    import gpio_pkg::*;

    typedef struct packed {
        byte_t port0_latch;
        byte_t port1_latch;
        byte_t port2_latch;
        byte_t pin_modulation_select;
        byte_t gen_config;
        byte_t port0_pullup_disable;
        byte_t port1_pullup_disable;
        byte_t port2_pullup_disable;
        byte_t rdata;
        logic [23:0] drive_level;
        logic [23:0] drive_en;
    } ports_s;

    ports_s state_reg;
    ports_s state_next;

    logic        carrier_wave;
    logic [23:0] pin_sync_level;
    logic [23:0] carrier_sel;
    logic [23:0] latch_all;
    logic [23:0] own_all;
    logic [23:0] pout_all;
    logic [23:0] pud_all;
    logic        carrier_global_enable;
    byte_t       carrier_pin_select_bits;
    logic [23:0] pin_level;

    carrier_gen #(
        .HALF_CYCLES (CARRIER_HALF)
    ) u_carrier (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .carrier_wave (carrier_wave)
    );

    pin_sync #(
        .WIDTH (24)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({port2_in, port1_in, port0_in}),
        .sync_out (pin_sync_level)
    );

    assign carrier_global_enable   = state_reg.gen_config[`CARRIER_ENABLE_BIT];
    assign carrier_pin_select_bits = state_reg.pin_modulation_select;

    always_comb
    begin
        carrier_sel     = 24'h000000;
        carrier_sel[14] = carrier_pin_select_bits[7];
        carrier_sel[13] = carrier_pin_select_bits[6];
        carrier_sel[12] = carrier_pin_select_bits[5];
        carrier_sel[9]  = carrier_pin_select_bits[4];
        carrier_sel[2]  = carrier_pin_select_bits[3];
        carrier_sel[7]  = carrier_pin_select_bits[2];
        carrier_sel[5]  = carrier_pin_select_bits[1];
        carrier_sel[3]  = carrier_pin_select_bits[0];
    end

    assign latch_all = {state_reg.port2_latch, state_reg.port1_latch, state_reg.port0_latch};
    assign own_all   = {periph_own2, periph_own1, periph_own0};
    assign pout_all  = {periph_out2, periph_out1, periph_out0};
    // reserved port 2 bits never act
    assign pud_all   = {state_reg.port2_pullup_disable & 8'h07,
                        state_reg.port1_pullup_disable, state_reg.port0_pullup_disable};

    // Level each pin should show, before the open-drain driver
    generate
        for (genvar i = 0; i < 24; i++)
        begin : g_pin
            logic carrier_on;
            logic gpio_level;
            assign carrier_on   = carrier_global_enable & carrier_sel[i];
            assign gpio_level   = latch_all[i] ^ (carrier_on & carrier_wave);
            assign pin_level[i] = own_all[i] ? pout_all[i] : gpio_level;
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        if (sfr_wr)
        begin
            case (sfr_addr)
                `ADDR_PORT0_LATCH:          state_next.port0_latch = sfr_wdata;
                `ADDR_PORT1_LATCH:          state_next.port1_latch = sfr_wdata;
                `ADDR_PORT2_LATCH:          state_next.port2_latch = sfr_wdata;
                `ADDR_PIN_MOD_SELECT:       state_next.pin_modulation_select = sfr_wdata;
                `ADDR_GEN_CONFIG:           state_next.gen_config = sfr_wdata;
                `ADDR_PORT0_PULLUP_DISABLE: state_next.port0_pullup_disable = sfr_wdata;
                `ADDR_PORT1_PULLUP_DISABLE: state_next.port1_pullup_disable = sfr_wdata;
                `ADDR_PORT2_PULLUP_DISABLE:
                    state_next.port2_pullup_disable = sfr_wdata & `PORT2_PULLUP_DISABLE_MASK;
                default:                    state_next.port0_latch = state_reg.port0_latch;
            endcase
        end
        state_next.rdata = 8'h00;
        case (sfr_rd_kind)
            READ_LATCH:
            begin
                case (sfr_addr)
                    `ADDR_PORT0_LATCH:          state_next.rdata = state_reg.port0_latch;
                    `ADDR_PORT1_LATCH:          state_next.rdata = state_reg.port1_latch;
                    `ADDR_PORT2_LATCH:          state_next.rdata = state_reg.port2_latch;
                    `ADDR_PIN_MOD_SELECT:       state_next.rdata = state_reg.pin_modulation_select;
                    `ADDR_GEN_CONFIG:           state_next.rdata = state_reg.gen_config;
                    `ADDR_PORT0_PULLUP_DISABLE: state_next.rdata = state_reg.port0_pullup_disable;
                    `ADDR_PORT1_PULLUP_DISABLE: state_next.rdata = state_reg.port1_pullup_disable;
                    `ADDR_PORT2_PULLUP_DISABLE: state_next.rdata = state_reg.port2_pullup_disable;
                    default:                    state_next.rdata = 8'h00;
                endcase
            end
            READ_PIN:
            begin
                case (sfr_addr)
                    `ADDR_PORT0_LATCH:          state_next.rdata = pin_sync_level[7:0];
                    `ADDR_PORT1_LATCH:          state_next.rdata = pin_sync_level[15:8];
                    `ADDR_PORT2_LATCH:          state_next.rdata = pin_sync_level[23:16];
                    `ADDR_PIN_MOD_SELECT:       state_next.rdata = state_reg.pin_modulation_select;
                    `ADDR_GEN_CONFIG:           state_next.rdata = state_reg.gen_config;
                    `ADDR_PORT0_PULLUP_DISABLE: state_next.rdata = state_reg.port0_pullup_disable;
                    `ADDR_PORT1_PULLUP_DISABLE: state_next.rdata = state_reg.port1_pullup_disable;
                    `ADDR_PORT2_PULLUP_DISABLE: state_next.rdata = state_reg.port2_pullup_disable;
                    default:                    state_next.rdata = 8'h00;
                endcase
            end
            default:
            begin
                state_next.rdata = state_reg.rdata;
            end
        endcase
        state_next.drive_level = 24'h000000;
        // never drive high; 1 means released
        state_next.drive_en    = ~pin_level;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.port0_latch           <= `PORT_LATCH_RESET;
            state_reg.port1_latch           <= `PORT_LATCH_RESET;
            state_reg.port2_latch           <= `PORT_LATCH_RESET;
            state_reg.pin_modulation_select <= `PIN_MOD_SELECT_RESET;
            state_reg.gen_config            <= `GEN_CONFIG_RESET;
            state_reg.port0_pullup_disable  <= `PULLUP_DISABLE_RESET;
            state_reg.port1_pullup_disable  <= `PULLUP_DISABLE_RESET;
            state_reg.port2_pullup_disable  <= `PULLUP_DISABLE_RESET;
            state_reg.rdata                 <= 8'h00;
            state_reg.drive_level           <= 24'h000000;
            state_reg.drive_en              <= 24'h000000;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata = state_reg.rdata;
    assign port0_out = state_reg.drive_level[7:0];
    assign port1_out = state_reg.drive_level[15:8];
    assign port2_out = state_reg.drive_level[23:16];
    assign port0_oe  = state_reg.drive_en[7:0];
    assign port1_oe  = state_reg.drive_en[15:8];
    assign port2_oe  = state_reg.drive_en[23:16];
    assign port0_pullup_en = ~pud_all[7:0];
    assign port1_pullup_en = ~pud_all[15:8];
    assign port2_pullup_en = ~pud_all[23:16];
    assign reset_pin_pullup_en = ~state_reg.port2_pullup_disable[`RESET_PIN_PULLUP_BIT];
endmodule // gpio_ports

// *** gpio_ports_properties.sv ***
// Assertions on the port block pins and register bus
`timescale 1ns/1ps
module gpio_ports_chk #(
    parameter int CARRIER_HALF = 4
) (
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic [7:0]           sfr_addr,
    input wire logic                 sfr_wr,
    input wire logic [7:0]           sfr_wdata,
    input wire gpio_pkg::read_kind_e sfr_rd_kind,
    input wire logic [7:0]           sfr_rdata,
    input wire logic [7:0]           periph_own0,
    input wire logic [7:0]           periph_own1,
    input wire logic [7:0]           periph_out1,
    input wire logic [7:0]           port0_in,
    input wire logic [7:0]           port0_out,
    input wire logic [7:0]           port0_oe,
    input wire logic [7:0]           port1_out,
    input wire logic [7:0]           port1_oe,
    input wire logic [7:0]           port0_pullup_en,
    input wire logic [7:0]           port1_pullup_en,
    input wire logic [7:0]           port2_pullup_en,
    input wire logic                 reset_pin_pullup_en
);
    import gpio_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_open_drain;
        ((port0_out & port0_oe) | (port1_out & port1_oe)) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_pu0;
        sfr_wr && sfr_addr == 8'hb2 |=> port0_pullup_en == ~$past(sfr_wdata);
    endproperty
    a_pu0: assert property (p_pu0) else $error("port0 pull-up mismatch");
    property p_pu2;
        sfr_wr && sfr_addr == 8'hb4 |=>
            {reset_pin_pullup_en, port2_pullup_en[2:0]} == ~{$past(sfr_wdata[5]), $past(sfr_wdata[2:0])};
    endproperty
    a_pu2: assert property (p_pu2) else $error("port2 pull-up mismatch");
    property p_reset_state;
        $past(rst) |-> port0_pullup_en == 8'hff && port1_pullup_en == 8'hff && port0_oe == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_latch_read;
        sfr_wr && sfr_addr == 8'h80 ##1 !sfr_wr ##1 sfr_rd_kind == READ_LATCH && sfr_addr == 8'h80
            |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read mismatch");
    property p_pin_read;
        sfr_rd_kind == READ_PIN && sfr_addr == 8'h80 |=> sfr_rdata == $past(port0_in, 3);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read mismatch");
    property p_oe_latch;
        sfr_wr && sfr_addr == 8'h80 ##1 periph_own0 == 8'h00
            |=> (port0_oe & 8'h53) == (~$past(sfr_wdata, 2) & 8'h53);
    endproperty
    a_oe_latch: assert property (p_oe_latch) else $error("port0 drive mismatch");
    property p_periph;
        $past(periph_own1) == 8'hff |-> port1_oe == ~$past(periph_out1);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral drive mismatch");
    c_pin_read: cover property (sfr_rd_kind == READ_PIN);
    c_carrier: cover property ($changed(port1_oe[1]));
    c_periph: cover property (periph_own1 == 8'hff);
endmodule // gpio_ports_chk

bind gpio_ports gpio_ports_chk #(.CARRIER_HALF(CARRIER_HALF)) chk_i (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd_kind(sfr_rd_kind), .sfr_rdata(sfr_rdata), .periph_own0(periph_own0),
    .periph_own1(periph_own1), .periph_out1(periph_out1), .port0_in(port0_in),
    .port0_out(port0_out), .port0_oe(port0_oe), .port1_out(port1_out), .port1_oe(port1_oe),
    .port0_pullup_en(port0_pullup_en), .port1_pullup_en(port1_pullup_en),
    .port2_pullup_en(port2_pullup_en), .reset_pin_pullup_en(reset_pin_pullup_en)
);

// *** pin_sync.sv ***
// Two-stage synchroniser for the pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    always_comb
    begin
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage2;
endmodule // pin_sync

// *** testbench.sv ***
// Self-checking bench for the port block
`timescale 1ns/1ps
module testbench;
    import gpio_pkg::*;
    logic       sys_clk = 0, rst = 1, sfr_wr = 0, rpu;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
    read_kind_e sfr_rd_kind = READ_NONE;
    logic [23:0] own = 0, pout = 24'hffffff, ext_en = 0, ext_val = 0;
    wire  [23:0] oe, pu, outs, lvl;
    int num_errors = 0, total_checks = 0;
    int pmap[8] = '{3, 5, 7, 2, 9, 12, 13, 14};
    logic [7:0] radr[9] = '{8'h80, 8'h90, 8'ha0, 8'h9f, 8'hb2, 8'hb3, 8'hb4, 8'haf, 8'h00};
    logic [7:0] rexp[9] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #12.5 sys_clk = ~sys_clk;
    gpio_ports #(.CARRIER_HALF(4)) dut (
        .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd_kind(sfr_rd_kind), .sfr_rdata(sfr_rdata),
        .periph_own0(own[7:0]), .periph_own1(own[15:8]), .periph_own2(own[23:16]),
        .periph_out0(pout[7:0]), .periph_out1(pout[15:8]), .periph_out2(pout[23:16]),
        .port0_in(lvl[7:0]), .port1_in(lvl[15:8]), .port2_in(lvl[23:16]),
        .port0_out(outs[7:0]), .port0_oe(oe[7:0]), .port0_pullup_en(pu[7:0]),
        .port1_out(outs[15:8]), .port1_oe(oe[15:8]), .port1_pullup_en(pu[15:8]),
        .port2_out(outs[23:16]), .port2_oe(oe[23:16]), .port2_pullup_en(pu[23:16]),
        .reset_pin_pullup_en(rpu)
    );
    ext_pins far_side (
        .sys_clk(sys_clk), .drv_en(oe), .drv_val(outs), .pullup_on(pu),
        .ext_en(ext_en), .ext_val(ext_val), .level(lvl)
    );
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input read_kind_e k, input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd_kind <= k;
        @(posedge sys_clk);
        sfr_rd_kind <= READ_NONE;
        #1 chk({16'h0, sfr_rdata}, {16'h0, e});
    endtask
    // Records which drive bits change and counts high cycles of drive bit b over two carrier periods
    task automatic watch(input logic [23:0] exp_chg, input int b, input logic [23:0] exp_hi);
        logic [23:0] prev, chg, highs;
        chg = 0;
        highs = 0;
        cyc(3);
        #1 prev = oe;
        repeat (16)
        begin
            @(posedge sys_clk);
            #1 chg |= prev ^ oe;
            prev = oe;
            highs += 24'(oe[b]);
        end
        chk(chg, exp_chg);
        chk(highs, exp_hi);
    endtask
    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        cyc(4);
        rst <= 1'b0;
        foreach (radr[i]) rd(READ_LATCH, radr[i], rexp[i]);
        chk({pu[18:0], rpu}, 20'hfffff);
        wr(8'hb2, 8'ha5);
        wr(8'hb3, 8'h3c);
        wr(8'hb4, 8'hff);
        rd(READ_PIN, 8'hb4, 8'h27);
        chk({rpu, pu[18:0]}, 24'h00c35a);
        wr(8'hb2, 8'h00);
        ext_en <= 24'h000002;
        wr(8'h80, 8'h5a);
        rd(READ_LATCH, 8'h80, 8'h5a);
        cyc(4);
        chk(oe[7:0], 8'ha5);
        rd(READ_PIN, 8'h80, 8'h58);
        wr(8'hb2, 8'hff);
        ext_en <= 24'h0000ff;
        ext_val <= 24'h00003c;
        wr(8'h80, 8'hff);
        cyc(4);
        chk(pu[7:0], 8'h00);
        rd(READ_PIN, 8'h80, 8'h3c);
        rd(READ_LATCH, 8'h80, 8'hff);
        wr(8'h90, 8'hff);
        own <= 24'h00ff00;
        pout <= 24'hff0fff;
        cyc(3);
        chk(oe[15:8], 8'hf0);
        own <= 24'h0;
        ext_en <= 24'h0;
        wr(8'h80, 8'h00);
        wr(8'h90, 8'h00);
        wr(8'haf, 8'h10);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h9f, 8'h01 << i);
            watch(24'h1 << pmap[i], pmap[i], 24'd8);
        end
        wr(8'haf, 8'hef);
        wr(8'h9f, 8'hff);
        watch(24'h0, 9, 24'd16);
        wr(8'haf, 8'h10);
        wr(8'h9f, 8'h00);
        watch(24'h0, 9, 24'd16);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rd(READ_LATCH, 8'hb2, 8'h00);
        rd(READ_LATCH, 8'h90, 8'hff);
        stop_test();
    end
endmodule // testbench
